/* File: core/fecgt_cfg.svh */
// offsets, field positions, reset values and counts of the equalizer/trim block
`ifndef FECGT_CFG_SVH
`define FECGT_CFG_SVH
`define FECGT_IDX_GAIN_B0_DUAL 12'h352
`define FECGT_IDX_GAIN_B1_DUAL 12'h353
`define FECGT_IDX_GAIN_A0_SINGLE 12'h354
`define FECGT_IDX_GAIN_A1_SINGLE 12'h355
`define FECGT_IDX_GAIN_B0_SINGLE 12'h356
`define FECGT_IDX_GAIN_B1_SINGLE 12'h357
`define FECGT_IDX_EQ_CFG 12'h400
`define FECGT_IDX_STATUS 12'h401
`define FECGT_IDX_COEF_A0 12'h418
`define FECGT_IDX_COEF_B0 12'h430
`define FECGT_IDX_COEF_STEP 12'h002
`define FECGT_NUM_REGS 17
`define FECGT_NUM_GAIN 6
`define FECGT_REG_CFG 6
`define FECGT_REG_COEF_A 7
`define FECGT_REG_COEF_B 12
`define FECGT_NTAPS 5
`define FECGT_CENTER_TAP 2
`define FECGT_CENTER_SHIFT 5
`define FECGT_FRAC_BITS 16
`define FECGT_MODE_ENABLE 2'h2
`define FECGT_SCW_MAX 3'h6
`define FECGT_MASK_BYTE 16'h00ff
`define FECGT_MASK_WORD 16'hffff
`define FECGT_RESET_VAL 16'h0000
`define FECGT_RESP_OKAY 2'h0
`define FECGT_RESP_SLVERR 2'h2
`define FECGT_FIFO_DEPTH 2'h2
`endif

/* File: core/fecgt_pkg.sv */
// types shared by the equalizer configuration and gain trim block
package fecgt_pkg;
	typedef logic signed [11:0] fecgt_sample_t;
	typedef struct packed {
		fecgt_sample_t a;
		fecgt_sample_t b;
	} fecgt_pair_t;
	typedef struct packed {
		logic [4:0] a0;
		logic [4:0] a1;
		logic [4:0] b0;
		logic [4:0] b1;
	} fecgt_gain_t;
	// index 0 is the first tap, applied to the newest sample
	typedef logic [4:0][11:0] fecgt_taps_t;
	// low seven bits of the equalizer configuration register
	typedef struct packed {
		logic share;
		logic merge;
		logic [2:0] scw;
		logic [1:0] mode;
	} fecgt_cfg_t;
endpackage

/* File: core/fecgt_top.sv */
// equalizer configuration, filter datapath and fine gain trims
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "fecgt_cfg.svh"
module fecgt_top (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [13:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [13:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic single_mode_i,
	input wire logic [5:0][4:0] fuse_gain_i,
	input wire fecgt_pkg::fecgt_pair_t in_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	output fecgt_pkg::fecgt_pair_t out_o,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output fecgt_pkg::fecgt_gain_t gain_o
);

	////////////////////////////////////////////////////////////////////////
	// decode and filter arithmetic helpers

	// register number to word index; used by write and read decode
	function automatic logic [11:0] reg_index(input int n);
		logic [11:0] step;
		step = `FECGT_IDX_COEF_STEP;
		case (n)
			0: reg_index = `FECGT_IDX_GAIN_B0_DUAL;
			1: reg_index = `FECGT_IDX_GAIN_B1_DUAL;
			2: reg_index = `FECGT_IDX_GAIN_A0_SINGLE;
			3: reg_index = `FECGT_IDX_GAIN_A1_SINGLE;
			4: reg_index = `FECGT_IDX_GAIN_B0_SINGLE;
			5: reg_index = `FECGT_IDX_GAIN_B1_SINGLE;
			6: reg_index = `FECGT_IDX_EQ_CFG;
			default: begin
				if (n < `FECGT_REG_COEF_B) begin
					reg_index = `FECGT_IDX_COEF_A0
						+ 12'(n - `FECGT_REG_COEF_A) * step;
				end else begin
					reg_index = `FECGT_IDX_COEF_B0
						+ 12'(n - `FECGT_REG_COEF_B) * step;
				end
			end
		endcase
	endfunction

	// returns {hit, register number}
	function automatic logic [5:0] decode(input logic [13:0] addr);
		decode = 6'h00;
		for (int n = 0; n < `FECGT_NUM_REGS; n++) begin
			if (reg_index(n) == addr[13:2]) begin
				decode = {1'b1, 5'(n)};
			end
		end
	endfunction

	// weighted sum in units of 2^-16; centre tap keeps a fixed weight
	function automatic logic signed [39:0] fir(
		input fecgt_pkg::fecgt_taps_t c,
		input fecgt_pkg::fecgt_taps_t x,
		input logic [2:0] scw
	);
		logic signed [23:0] p;
		fir = 40'sh00_0000_0000;
		for (int k = 0; k < `FECGT_NTAPS; k++) begin
			p = $signed(c[k]) * $signed(x[k]);
			if (k == `FECGT_CENTER_TAP) begin
				fir = fir + (40'(p) <<< `FECGT_CENTER_SHIFT);
			end else begin
				fir = fir + (40'(p) <<< scw);
			end
		end
	endfunction

	// back to sample units with saturation instead of wrap
	function automatic logic [11:0] sat(input logic signed [39:0] acc);
		logic signed [39:0] s;
		s = acc >>> `FECGT_FRAC_BITS;
		if (s > 40'sd2047) begin
			sat = 12'h7ff;
		end else if (s < -40'sd2048) begin
			sat = 12'h800;
		end else begin
			sat = s[11:0];
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// register file and bus slave

	logic [15:0] regf_reg [`FECGT_NUM_REGS];
	logic [15:0] regf_next [`FECGT_NUM_REGS];
	logic load_pend_reg, load_pend_next;
	logic aw_held_reg, aw_held_next, w_held_reg, w_held_next;
	logic [13:0] awaddr_reg, awaddr_next;
	logic [31:0] wdata_reg, wdata_next;
	logic [3:0] wstrb_reg, wstrb_next;
	logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
	logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;
	fecgt_pkg::fecgt_gain_t gain_reg, gain_next;
	logic [5:0] wr_sel, rd_sel;
	logic [15:0] wmask;
	logic rd_status;
	fecgt_pkg::fecgt_cfg_t cfg;
	logic eq_on;
	logic [2:0] scw_eff;
	fecgt_pkg::fecgt_taps_t coef_a, coef_b;
	logic [1:0] fifo_cnt_reg;

	assign wr_sel = decode(awaddr_reg);
	assign rd_sel = decode(s_axi_araddr_i);
	assign rd_status = s_axi_araddr_i[13:2] == `FECGT_IDX_STATUS;
	assign wmask = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
	// a channel is offered only while its slot is free and no answer waits
	assign s_axi_awready_o = !aw_held_reg && !bvalid_reg;
	assign s_axi_wready_o = !w_held_reg && !bvalid_reg;
	assign s_axi_arready_o = !rvalid_reg;
	assign s_axi_bvalid_o = bvalid_reg;
	assign s_axi_bresp_o = bresp_reg;
	assign s_axi_rvalid_o = rvalid_reg;
	assign s_axi_rresp_o = rresp_reg;
	assign s_axi_rdata_o = rdata_reg;
	assign gain_o = gain_reg;

	// effective settings; bit 7 and upper coefficient bits are ignored
	assign cfg = fecgt_pkg::fecgt_cfg_t'(regf_reg[`FECGT_REG_CFG][6:0]);
	assign eq_on = cfg.mode == `FECGT_MODE_ENABLE;
	// out-of-range weight 7 is clamped to the maximum weight 6 rather than used as it stands
	assign scw_eff = (cfg.scw > `FECGT_SCW_MAX) ? `FECGT_SCW_MAX : cfg.scw;
	for (genvar k = 0; k < `FECGT_NTAPS; k++) begin : g_taps
		assign coef_a[k] = regf_reg[`FECGT_REG_COEF_A + k][11:0];
		assign coef_b[k] = cfg.share ? coef_a[k]
			: regf_reg[`FECGT_REG_COEF_B + k][11:0];
	end

	// writes complete once address and data are both held
	always_comb begin
		regf_next = regf_reg;
		load_pend_next = 1'b0;
		aw_held_next = aw_held_reg;
		w_held_next = w_held_reg;
		awaddr_next = awaddr_reg;
		wdata_next = wdata_reg;
		wstrb_next = wstrb_reg;
		bvalid_next = bvalid_reg && !s_axi_bready_i;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg && !s_axi_rready_i;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		if (s_axi_awvalid_i && s_axi_awready_o) begin
			aw_held_next = 1'b1;
			awaddr_next = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && s_axi_wready_o) begin
			w_held_next = 1'b1;
			wdata_next = s_axi_wdata_i;
			wstrb_next = s_axi_wstrb_i;
		end
		if (aw_held_reg && w_held_reg) begin
			aw_held_next = 1'b0;
			w_held_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = wr_sel[5] ? `FECGT_RESP_OKAY : `FECGT_RESP_SLVERR;
			for (int n = 0; n < `FECGT_NUM_REGS; n++) begin
				if (wr_sel[5] && wr_sel[4:0] == 5'(n)) begin
					regf_next[n] = (regf_reg[n] & ~(wmask & reg_mask(n)))
						| (wdata_reg[15:0] & wmask & reg_mask(n));
				end
			end
		end
		// fuse defaults land on the first edge after reset release
		if (load_pend_reg) begin
			for (int n = 0; n < `FECGT_NUM_GAIN; n++) begin
				regf_next[n][4:0] = fuse_gain_i[n];
			end
		end
		if (s_axi_arvalid_i && s_axi_arready_o) begin
			rvalid_next = 1'b1;
			rresp_next = (rd_sel[5] || rd_status) ? `FECGT_RESP_OKAY
				: `FECGT_RESP_SLVERR;
			rdata_next = 32'h0000_0000;
			if (rd_sel[5]) begin
				rdata_next[15:0] = regf_reg[rd_sel[4:0]];
			end else if (rd_status) begin
				rdata_next[3:0] = {fifo_cnt_reg, single_mode_i, eq_on};
			end
		end
		// dual trims for channel A live outside this block
		if (single_mode_i) begin
			gain_next.a0 = regf_reg[2][4:0];
			gain_next.a1 = regf_reg[3][4:0];
			gain_next.b0 = regf_reg[4][4:0];
			gain_next.b1 = regf_reg[5][4:0];
		end else begin
			gain_next.a0 = 5'h00;
			gain_next.a1 = 5'h00;
			gain_next.b0 = regf_reg[0][4:0];
			gain_next.b1 = regf_reg[1][4:0];
		end
	end

	// gain and config registers are 8 bits wide, coefficients 16
	function automatic logic [15:0] reg_mask(input int n);
		reg_mask = (n <= `FECGT_REG_CFG) ? `FECGT_MASK_BYTE : `FECGT_MASK_WORD;
	endfunction

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			for (int n = 0; n < `FECGT_NUM_REGS; n++) begin
				regf_reg[n] <= `FECGT_RESET_VAL;
			end
			load_pend_reg <= 1'b1;
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= 14'h0000;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= `FECGT_RESP_OKAY;
			rvalid_reg <= 1'b0;
			rresp_reg <= `FECGT_RESP_OKAY;
			rdata_reg <= 32'h0000_0000;
			gain_reg <= '0;
		end else begin
			regf_reg <= regf_next;
			load_pend_reg <= load_pend_next;
			aw_held_reg <= aw_held_next;
			w_held_reg <= w_held_next;
			awaddr_reg <= awaddr_next;
			wdata_reg <= wdata_next;
			wstrb_reg <= wstrb_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
			gain_reg <= gain_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// filter datapath and two-entry output buffer

	logic [3:0][11:0] hist_a_reg, hist_a_next, hist_b_reg, hist_b_next;
	fecgt_pkg::fecgt_pair_t mem_reg [2];
	fecgt_pkg::fecgt_pair_t mem_next [2];
	fecgt_pkg::fecgt_pair_t res;
	logic wptr_reg, wptr_next, rptr_reg, rptr_next;
	logic [1:0] fifo_cnt_next;
	logic take, give;

	// a full buffer stalls the source, so no filtered word is dropped
	assign in_ready_o = fifo_cnt_reg != `FECGT_FIFO_DEPTH;
	assign out_valid_o = fifo_cnt_reg != 2'h0;
	assign out_o = mem_reg[rptr_reg];
	assign take = in_valid_i && in_ready_o;
	assign give = out_valid_o && out_ready_i;

	// history index 0 is the previous sample of that channel
	always_comb begin
		hist_a_next = hist_a_reg;
		hist_b_next = hist_b_reg;
		mem_next = mem_reg;
		wptr_next = wptr_reg;
		rptr_next = rptr_reg;
		fifo_cnt_next = fifo_cnt_reg;
		res = in_i;
		if (eq_on && cfg.merge) begin
			// one stream ordered a then b, both on A taps
			res.a = sat(fir(coef_a, {hist_a_reg[1], hist_b_reg[1],
				hist_a_reg[0], hist_b_reg[0], in_i.a}, scw_eff));
			res.b = sat(fir(coef_a, {hist_b_reg[1], hist_a_reg[0],
				hist_b_reg[0], in_i.a, in_i.b}, scw_eff));
		end else if (eq_on) begin
			res.a = sat(fir(coef_a, {hist_a_reg, in_i.a}, scw_eff));
			res.b = sat(fir(coef_b, {hist_b_reg, in_i.b}, scw_eff));
		end
		if (take) begin
			hist_a_next = {hist_a_reg[2:0], in_i.a};
			hist_b_next = {hist_b_reg[2:0], in_i.b};
			mem_next[wptr_reg] = res;
			wptr_next = !wptr_reg;
		end
		if (give) begin
			rptr_next = !rptr_reg;
		end
		fifo_cnt_next = fifo_cnt_reg + 2'(take) - 2'(give);
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			hist_a_reg <= '0;
			hist_b_reg <= '0;
			mem_reg[0] <= '0;
			mem_reg[1] <= '0;
			wptr_reg <= 1'b0;
			rptr_reg <= 1'b0;
			fifo_cnt_reg <= 2'h0;
		end else begin
			hist_a_reg <= hist_a_next;
			hist_b_reg <= hist_b_next;
			mem_reg <= mem_next;
			wptr_reg <= wptr_next;
			rptr_reg <= rptr_next;
			fifo_cnt_reg <= fifo_cnt_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);

	sequence s_bus_write;
		s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
	endsequence
	sequence s_empty_take;
		take && fifo_cnt_reg == 2'h0;
	endsequence

	property p_fuse;
		$fell(reset_i) |=> regf_reg[0][4:0] == $past(fuse_gain_i[0])
			&& regf_reg[5][4:0] == $past(fuse_gain_i[5]);
	endproperty
	a_fuse: assert property (p_fuse) else $error("fuse trims not loaded");

	property p_share;
		s_empty_take ##0 (eq_on && cfg.share && !cfg.merge
			&& in_i.a == in_i.b && hist_a_reg == hist_b_reg)
			|=> out_o.a == out_o.b;
	endproperty
	a_share: assert property (p_share) else $error("B not on A taps");

	property p_bypass;
		s_empty_take ##0 !eq_on |=> out_valid_o && out_o == $past(in_i);
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass altered data");

	property p_scw;
		cfg.scw == 3'h7 |-> scw_eff == `FECGT_SCW_MAX;
	endproperty
	a_scw: assert property (p_scw) else $error("side weight not clamped");

	property p_gain_dual;
		!single_mode_i |=> gain_o.b0 == $past(regf_reg[0][4:0])
			&& gain_o.a0 == 5'h00;
	endproperty
	a_gain_dual: assert property (p_gain_dual) else $error("dual trim wrong");

	property p_gain_single;
		single_mode_i |=> gain_o.a1 == $past(regf_reg[3][4:0])
			&& gain_o.b1 == $past(regf_reg[5][4:0]);
	endproperty
	a_gain_single: assert property (p_gain_single) else $error("single trim wrong");

	property p_write;
		s_bus_write |-> ##2 s_axi_bvalid_o;
	endproperty
	a_write: assert property (p_write) else $error("write answer late");

	property p_read;
		s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o
			&& s_axi_rdata_o[31:16] == 16'h0000;
	endproperty
	a_read: assert property (p_read) else $error("read answer wrong");

	property p_stall;
		out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_o);
	endproperty
	a_stall: assert property (p_stall) else $error("stalled word changed");

endmodule
`default_nettype wire

/* File: dv/fecgt_top_test.sv */
// self-checking bench of the equalizer configuration and gain trim block
`timescale 1ns/1ns
`default_nettype none
`include "fecgt_cfg.svh"
module fecgt_top_test;
typedef struct packed {
	logic [11:0] idx;
	logic [15:0] w;
	logic [15:0] r;
	logic [1:0] resp;
} fecgt_row_t;
logic clk_i, reset_i, awv, wv, arv, single, inv, outr, awr, wr_o, bv;
logic arr, rv, inr, outv;
logic [13:0] awa, ara;
logic [31:0] wd, rd;
logic [3:0] strb;
logic [1:0] bresp, rresp;
fecgt_pkg::fecgt_pair_t din, dout;
fecgt_pkg::fecgt_gain_t gain;
fecgt_pkg::fecgt_cfg_t cfg;
logic [5:0][4:0] fuse = {5'h1c, 5'h16, 5'h11, 5'h0a, 5'h05, 5'h03};
logic [4:0][11:0] ca, cb, ha, hb, hm;
logic [5:0][4:0] gv;
logic [23:0] smp [6] = '{24'h400_c00, 24'h100_800, 24'hf00_700,
	24'h800_400, 24'h200_f00, 24'h000_100};
fecgt_row_t rows [6] = '{'{12'h400, 16'hffff, 16'h00ff, 2'h0},
	'{12'h352, 16'habcd, 16'h00cd, 2'h0},
	'{12'h357, 16'h001f, 16'h001f, 2'h0},
	'{12'h418, 16'hffff, 16'hffff, 2'h0},
	'{12'h438, 16'h1234, 16'h1234, 2'h0},
	'{12'h3ff, 16'h5555, 16'h0000, 2'h2}};
int error_cnt, samples_checked, cyc;
fecgt_top DUT (.clk_i(clk_i), .reset_i(reset_i), .s_axi_awaddr_i(awa),
	.s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
	.s_axi_wstrb_i(strb), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_o),
	.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(1'b1),
	.s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
	.s_axi_rdata_o(rd), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv),
	.s_axi_rready_i(1'b1), .single_mode_i(single), .fuse_gain_i(fuse),
	.in_i(din), .in_valid_i(inv), .in_ready_o(inr), .out_o(dout),
	.out_valid_o(outv), .out_ready_i(outr), .gain_o(gain));
////////////////////////////////////////////////////////////////////////
task automatic check(input logic [31:0] s, input logic [31:0] e);
	samples_checked++;
	if (s !== e) begin
		error_cnt++;
		$display("Error at %0t: seen %h expected %h", $time, s, e);
	end
endtask
task automatic complete_run;
	$display("checks %0d, mismatches %0d", samples_checked, error_cnt);
	if (error_cnt == 0 && samples_checked > 0) begin
		$display("Test passed");
	end else begin
		$display("Test failed");
	end
	$finish;
endtask
// write with address and data offered together, each dropped when taken
task automatic wr(input logic [11:0] idx, input logic [15:0] d,
	input logic [1:0] er);
	logic ad, dd;
	ad = 0;
	dd = 0;
	@(posedge clk_i);
	awa <= {idx, 2'b00};
	wd <= {16'h0000, d};
	awv <= 1'b1;
	wv <= 1'b1;
	while (!(ad && dd)) begin
		@(posedge clk_i);
		if (!ad && awr) begin
			ad = 1;
			awv <= 1'b0;
		end
		if (!dd && wr_o) begin
			dd = 1;
			wv <= 1'b0;
		end
	end
	do @(posedge clk_i); while (!bv);
	check(bresp, er);
endtask
task automatic rdc(input logic [11:0] idx, input logic [31:0] e,
	input logic [1:0] er);
	@(posedge clk_i);
	ara <= {idx, 2'b00};
	arv <= 1'b1;
	do @(posedge clk_i); while (!arr);
	arv <= 1'b0;
	do @(posedge clk_i); while (!rv);
	check(rd, e);
	check(rresp, er);
endtask
task automatic setcfg(input logic [7:0] v);
	cfg = v[6:0];
	wr(`FECGT_IDX_EQ_CFG, {8'h00, v}, 2'h0);
endtask
////////////////////////////////////////////////////////////////////////
// reference filter: exact sum, floor shift, saturation to 12 bits
function automatic logic [11:0] fir(input logic [4:0][11:0] c,
	input logic [4:0][11:0] h, input logic [2:0] w);
	longint acc;
	acc = 0;
	for (int k = 0; k < 5; k++) begin
		acc += (longint'($signed(c[k])) * $signed(h[k]))
			<<< (k == 2 ? 5 : (w > 3'h6 ? 6 : w));
	end
	acc = acc >>> 16;
	return acc > 2047 ? 12'h7ff : acc < -2048 ? 12'h800 : acc[11:0];
endfunction
task automatic push(input logic [11:0] a, input logic [11:0] b);
	din <= {a, b};
	inv <= 1'b1;
	do @(posedge clk_i); while (!inr);
endtask
task automatic pop(input logic [23:0] e);
	do @(posedge clk_i); while (!outv);
	check(dout, e);
endtask
// one beat through the filter; the histories are kept beside the design
task automatic beat(input logic [11:0] a, input logic [11:0] b);
	logic [11:0] ea, eb;
	ea = a;
	eb = b;
	if (cfg.mode == 2'h2 && cfg.merge) begin
		hm = {hm[3:0], a};
		ea = fir(ca, hm, cfg.scw);
		hm = {hm[3:0], b};
		eb = fir(ca, hm, cfg.scw);
	end else if (cfg.mode == 2'h2) begin
		ha = {ha[3:0], a};
		hb = {hb[3:0], b};
		ea = fir(ca, ha, cfg.scw);
		eb = fir(cfg.share ? ca : cb, hb, cfg.scw);
	end
	push(a, b);
	inv <= 1'b0;
	pop({ea, eb});
endtask
task automatic run_all;
	for (int i = 0; i < 6; i++) begin
		beat(smp[i][23:12], smp[i][11:0]);
	end
endtask
////////////////////////////////////////////////////////////////////////
initial begin
	clk_i = 0;
	forever #5 clk_i = ~clk_i;
end
// hang guard: the whole sequence needs a few hundred cycles
always @(posedge clk_i) begin
	cyc++;
	if (cyc == 20000) begin
		error_cnt++;
		complete_run();
	end
end
initial begin
	{reset_i, awv, wv, arv, single, inv, outr} = 7'b1000001;
	{awa, ara, wd, din} = '0;
	strb = 4'hf;
	{ha, hb, hm} = '0;
	ca = {12'hfc0, 12'h020, 12'h400, 12'hfe0, 12'h040};
	cb = {12'h100, 12'h000, 12'hc00, 12'h020, 12'h7e0};
	repeat (10) @(posedge clk_i);
	reset_i <= 1'b0;
	repeat (3) @(posedge clk_i);
	check(gain, {10'h000, fuse[0], fuse[1]});
	for (int k = 0; k < 6; k++) begin
		rdc(12'h352 + 12'(k), {27'h0, fuse[k]}, 2'h0);
	end
	rdc(`FECGT_IDX_EQ_CFG, 32'h0000_0000, 2'h0);
	$display("reset test done");
	// ordinary register rows: store, read back, byte masks, unmapped
	foreach (rows[i]) begin
		wr(rows[i].idx, rows[i].w, rows[i].resp);
		rdc(rows[i].idx, {16'h0000, rows[i].r}, rows[i].resp);
	end
	wr(`FECGT_IDX_STATUS, 16'h00ff, 2'h2);
	// upper byte lane only: the low byte of the tap must survive
	strb <= 4'h2;
	wr(12'h438, 16'hee99, 2'h0);
	strb <= 4'hf;
	rdc(12'h438, 32'h0000_ee34, 2'h0);
	$display("register rows done");
	// reserved trim bits are set and must not reach the trims
	for (int k = 0; k < 6; k++) begin
		gv[k] = 5'(k * 5 + 1);
		wr(12'h352 + 12'(k), {11'h007, gv[k]}, 2'h0);
	end
	repeat (2) @(posedge clk_i);
	check(gain, {10'h000, gv[0], gv[1]});
	single <= 1'b1;
	repeat (3) @(posedge clk_i);
	check(gain, {gv[2], gv[3], gv[4], gv[5]});
	single <= 1'b0;
	$display("gain trim test done");
	for (int k = 0; k < 5; k++) begin
		wr(`FECGT_IDX_COEF_A0 + 12'(2 * k), {4'hf, ca[k]}, 2'h0);
		wr(`FECGT_IDX_COEF_B0 + 12'(2 * k), {4'h5, cb[k]}, 2'h0);
	end
	// settings change only while the stream is idle
	setcfg(8'h5a);
	// equal samples on clean histories: B on A taps gives equal halves
	beat(12'h321, 12'h321);
	run_all();
	setcfg(8'h1a);
	run_all();
	setcfg(8'h0e);
	run_all();
	setcfg(8'h9e);
	run_all();
	repeat (5) beat(12'h000, 12'h000);
	single <= 1'b1;
	setcfg(8'h7a);
	run_all();
	$display("filter test done");
	// reserved modes must behave as disabled
	foreach (smp[i]) begin
		if (i < 3) begin
			setcfg({6'h00, i == 0 ? 2'h0 : 2'(i * 2 - 1)});
			beat(12'h123, 12'hedc);
		end
	end
	setcfg(8'h00);
	// receiver stalls: two words held, third refused, order kept
	outr <= 1'b0;
	push(12'h111, 12'h222);
	push(12'h333, 12'h444);
	din <= {12'h555, 12'h666};
	repeat (2) @(posedge clk_i);
	check(inr, 1'b0);
	inv <= 1'b0;
	rdc(`FECGT_IDX_STATUS, 32'h0000_000a, 2'h0);
	outr <= 1'b1;
	pop(24'h111_222);
	pop(24'h333_444);
	$display("buffer test done");
	// mid-run reset: settings clear, fuse trims come back
	reset_i <= 1'b1;
	repeat (3) @(posedge clk_i);
	reset_i <= 1'b0;
	repeat (3) @(posedge clk_i);
	check(gain, {fuse[2], fuse[3], fuse[4], fuse[5]});
	rdc(`FECGT_IDX_EQ_CFG, 32'h0000_0000, 2'h0);
	rdc(`FECGT_IDX_STATUS, 32'h0000_0002, 2'h0);
	$display("mid-run reset test done");
	complete_run();
end
endmodule
`default_nettype wire
